// ==== dv/conv_source.sv ====
module conv_source (
    input wire logic [15:0] level,
    input wire logic [7:0] pin_fire,
    input wire logic [3:0] chan_fire,
    output logic [15:0] volt_sample,
    output logic [15:0] curr_sample,
    output logic [7:0] trig_pins,
    output logic [3:0] transient_trig_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // Converters hold a steady level, current differs so the two can be told apart
    assign volt_sample = level;
    assign curr_sample = level ^ 16'h0055;
    assign trig_pins = pin_fire;
    assign transient_trig_out = chan_fire;
endmodule

// ==== dv/test_digitizer_acquisition_trigger.sv ====
module test_digitizer_acquisition_trigger;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, pin_fire = 8'h00, pins;
    logic [31:0] pwdata = 32'h0, prdata, seed = 32'h62;
    logic pready, pslverr, armed, acq_done;
    logic [15:0] level = 16'h0, vs, cs;
    logic [3:0] chan_fire = 4'h0, tto;
    logic [32:0] exp_q[$];
    logic [32:0] e;
    int error_cnt = 0, checks_done = 0;
    always #2 pclk = ~pclk;
    conv_source i_conv_source (.level(level), .pin_fire(pin_fire), .chan_fire(chan_fire),
        .volt_sample(vs), .curr_sample(cs), .trig_pins(pins), .transient_trig_out(tto));
    digitizer_acquisition_trigger #(.tick_cycles(4)) i_digitizer_acquisition_trigger (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .volt_sample(vs), .curr_sample(cs),
        .trig_pins(pins), .transient_trig_out(tto), .armed(armed), .acq_done(acq_done));
    // ==========================================
    // Bus tasks and checks
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] x);
        exp_q.push_back(x);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic lv(input logic got, input logic x);
        checks_done++;
        if (got !== x) begin
            error_cnt++;
            $display("MISMATCH level exp %b got %b", x, got);
        end
    endtask
    task automatic wait_idle();
        repeat (400) begin
            @(posedge pclk);
            if (armed === 1'b0) break;
        end
        @(posedge pclk);
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic tally_and_finish();
        if (exp_q.size() != 0) begin
            error_cnt++;
            $display("MISMATCH pending reads exp 0 got %0d", exp_q.size());
        end
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ==========================================
    // Result monitor
    always @(posedge pclk) if (psel && penable && pready === 1'b1 && !pwrite) begin
        e = exp_q.pop_front();
        checks_done++;
        if (e[32] ? pslverr !== 1'b1 : {pslverr, prdata} !== e) begin
            error_cnt++;
            $display("MISMATCH read %h exp %h got %h", paddr, e, {pslverr, prdata});
        end
    end
    initial begin
        #100000;
        error_cnt++;
        tally_and_finish();
    end
    // ==========================================
    // Scenarios
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(digitizer_pkg::config_addr, 33'h0);
        rd(digitizer_pkg::interval_addr, 33'h5000);
        rd(8'h40, {1'b1, 32'h0});
        wr(digitizer_pkg::interval_addr, 32'hea60);
        rd(digitizer_pkg::interval_addr, 33'hf000);
        wr(digitizer_pkg::interval_addr, 32'h5000);
        wr(digitizer_pkg::points_addr, 32'h4);
        wr(digitizer_pkg::ctrl_addr, 32'h1 << digitizer_pkg::cmd_trig_bit);
        lv(armed, 1'b0);
        $display("register test done");
        seed = xs(seed);
        level <= {1'b0, seed[14:0]};
        wr(digitizer_pkg::config_addr, 32'h0210);
        wr(digitizer_pkg::ctrl_addr, 32'h1 << digitizer_pkg::cmd_arm_bit);
        lv(armed, 1'b1);
        fork
            rd(digitizer_pkg::volt_data_addr, {17'h0, seed[14:0]});
            begin
                repeat (30) @(posedge pclk);
                pin_fire[2] <= 1'b1;
                repeat (3) @(posedge pclk);
                pin_fire[2] <= 1'b0;
            end
        join
        wait_idle();
        lv(acq_done, 1'b1);
        rd(digitizer_pkg::mean_volt_addr, {17'h0, seed[14:0]});
        rd(digitizer_pkg::curr_data_addr, {17'h0, seed[14:0] ^ 15'h0055});
        rd(digitizer_pkg::volt_data_addr, {17'h0, seed[14:0]});
        $display("pin trigger test done");
        wr(digitizer_pkg::config_addr, 32'h0120);
        wr(digitizer_pkg::ctrl_addr, 32'h1 << digitizer_pkg::cmd_arm_bit);
        repeat (50) @(posedge pclk);
        lv(armed, 1'b1);
        wr(digitizer_pkg::ctrl_addr, 32'h1 << digitizer_pkg::cmd_cancel_bit);
        lv(armed, 1'b0);
        wr(digitizer_pkg::ctrl_addr, 32'h1 << digitizer_pkg::cmd_arm_bit);
        chan_fire[1] <= 1'b1;
        repeat (3) @(posedge pclk);
        chan_fire[1] <= 1'b0;
        wait_idle();
        lv(acq_done, 1'b1);
        $display("transient and cancel test done");
        seed = xs(seed);
        level <= {1'b0, seed[14:0]};
        wr(digitizer_pkg::offset_addr, 32'hfffffffe);
        wr(digitizer_pkg::ctrl_addr, 32'h1 << digitizer_pkg::cmd_arm_bit);
        wr(digitizer_pkg::ctrl_addr, 32'h1 << digitizer_pkg::cmd_trig_bit);
        repeat (40) @(posedge pclk);
        lv(armed, 1'b1);
        level <= level ^ 16'h00ff;
        wr(digitizer_pkg::ctrl_addr, 32'h1 << digitizer_pkg::cmd_trig_bit);
        wait_idle();
        rd(digitizer_pkg::volt_data_addr, {17'h0, seed[14:0]});
        rd(digitizer_pkg::mean_volt_addr, {17'h0, seed[14:0] ^ 15'h00ff});
        $display("pre-trigger test done");
        wr(digitizer_pkg::offset_addr, 32'h3);
        wr(digitizer_pkg::ctrl_addr, 32'h1 << digitizer_pkg::cmd_arm_bit);
        wr(digitizer_pkg::ctrl_addr, 32'h1 << digitizer_pkg::cmd_trig_bit);
        // Without the skipped samples the record would be complete by now
        repeat (16) @(posedge pclk);
        lv(armed, 1'b1);
        wait_idle();
        lv(acq_done, 1'b1);
        $display("positive offset test done");
        wr(digitizer_pkg::offset_addr, 32'h0);
        wr(digitizer_pkg::config_addr, 32'h1);
        rd(digitizer_pkg::config_addr, 33'h1);
        wr(digitizer_pkg::ctrl_addr, 32'h1 << digitizer_pkg::cmd_measure_bit);
        wait_idle();
        lv(acq_done, 1'b1);
        rd(digitizer_pkg::mean_volt_addr, {17'h0, seed[14:0] ^ 15'h00ff});
        $display("measure test done");
        tally_and_finish();
    end
endmodule

// ==== hdl/digitizer_acquisition_trigger.sv ====
// Decided for this implementation: the APB register port and the address map.
module digitizer_acquisition_trigger #(
    parameter int depth_log2 = 12,
    parameter int sample_width = 16,
    parameter int num_pins = 8,
    parameter int num_channels = 4,
    parameter bit dual_converter = 1'b1,
    parameter int tick_cycles = digitizer_pkg::tick_cycles
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [sample_width-1:0] volt_sample,
    input wire logic [sample_width-1:0] curr_sample,
    input wire logic [num_pins-1:0] trig_pins,
    input wire logic [num_channels-1:0] transient_trig_out,
    output logic armed,
    output logic acq_done
);
    localparam int depth = 1 << depth_log2;
    localparam int cosine_weighted_window_w = 8;
    localparam int acc_w = sample_width + depth_log2 + cosine_weighted_window_w;

    typedef enum logic [1:0] {st_idle, st_pre, st_wait, st_post} acq_state_e;
    acq_state_e state;

    // ===================================================
    // Registers
    logic [15:0] interval_ticks;
    logic [depth_log2:0] point_total;
    logic signed [31:0] trig_offset;
    logic window_sel;
    logic quantity_sel;
    logic [1:0] src_sel;
    logic [3:0] src_index;
    logic [depth_log2-1:0] read_index;
    logic data_valid;
    logic measure_pending;

    // Sample memory
    logic [sample_width-1:0] volt_mem [depth];
    logic [sample_width-1:0] curr_mem [depth];

    // ===================================================
    // Bus decode
    wire access_write = psel && penable && pwrite && pready;
    wire addr_known = paddr == digitizer_pkg::ctrl_addr || paddr == digitizer_pkg::interval_addr ||
        paddr == digitizer_pkg::points_addr || paddr == digitizer_pkg::offset_addr ||
        paddr == digitizer_pkg::config_addr || paddr == digitizer_pkg::status_addr ||
        paddr == digitizer_pkg::read_addr || paddr == digitizer_pkg::volt_data_addr ||
        paddr == digitizer_pkg::curr_data_addr || paddr == digitizer_pkg::mean_volt_addr ||
        paddr == digitizer_pkg::mean_curr_addr;
    wire ctrl_wr = access_write && paddr == digitizer_pkg::ctrl_addr;
    wire cmd_arm = ctrl_wr && pwdata[digitizer_pkg::cmd_arm_bit];
    wire cmd_trig = ctrl_wr && pwdata[digitizer_pkg::cmd_trig_bit];
    wire cmd_cancel = ctrl_wr && pwdata[digitizer_pkg::cmd_cancel_bit];
    wire cmd_measure = ctrl_wr && pwdata[digitizer_pkg::cmd_measure_bit];
    wire cmd_bus_trig = ctrl_wr && pwdata[digitizer_pkg::cmd_bus_trig_bit];
    wire data_addr = paddr == digitizer_pkg::volt_data_addr || paddr == digitizer_pkg::curr_data_addr ||
        paddr == digitizer_pkg::mean_volt_addr || paddr == digitizer_pkg::mean_curr_addr;
    // Data reads stall until the acquisition has completed
    wire fetch_hold = psel && penable && !pwrite && data_addr && !data_valid;

    // Round ns to nearest tick multiple: (ns + tick/2) / tick, at least one
    function automatic logic [15:0] round_ticks(input logic [31:0] ns);
        logic [31:0] q;
        q = (ns + 32'(digitizer_pkg::base_tick_ns / 2)) / 32'(digitizer_pkg::base_tick_ns);
        if (q < 32'(digitizer_pkg::min_interval_ticks)) begin
            q = 32'(digitizer_pkg::min_interval_ticks);
        end
        // Saturate so a huge request never wraps to a zero interval
        if (q > 32'h0000_ffff) begin
            q = 32'h0000_ffff;
        end
        return q[15:0];
    endfunction

    // ===================================================
    // Input synchronisers
    logic [num_pins-1:0] pin_s1, pin_s2, pin_s3;
    logic [num_channels-1:0] tr_s1, tr_s2, tr_s3;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            pin_s3 <= '0;
            tr_s1 <= '0;
            tr_s2 <= '0;
            tr_s3 <= '0;
        end else begin
            pin_s1 <= trig_pins;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            tr_s1 <= transient_trig_out;
            tr_s2 <= tr_s1;
            tr_s3 <= tr_s2;
        end
    end
    wire [num_pins-1:0] pin_rise = pin_s2 & ~pin_s3;
    wire [num_channels-1:0] tr_rise = tr_s2 & ~tr_s3;

    // ===================================================
    // Trigger selection
    wire src_event = (src_sel == 2'(digitizer_pkg::src_bus) && cmd_bus_trig) ||
        (src_sel == 2'(digitizer_pkg::src_pin) && pin_rise[src_index[$clog2(num_pins)-1:0]]) ||
        (src_sel == 2'(digitizer_pkg::src_transient) &&
         tr_rise[src_index[$clog2(num_channels)-1:0]]);
    wire trig_event = src_event || cmd_trig || measure_pending;

    // ===================================================
    // Sample tick
    logic [$clog2(tick_cycles)-1:0] base_cnt;
    logic [15:0] ival_cnt;
    wire base_tick = base_cnt == '0;
    wire sample_strobe = base_tick && ival_cnt == digitizer_pkg::min_interval_ticks;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_cnt <= '0;
            ival_cnt <= digitizer_pkg::min_interval_ticks;
        end else begin
            base_cnt <= base_tick ? $bits(base_cnt)'(tick_cycles - 1) : base_cnt - 1'b1;
            if (base_tick) begin
                ival_cnt <= sample_strobe ? interval_ticks : ival_cnt - 1'b1;
            end
        end
    end

    // ===================================================
    // Acquisition control
    wire neg_off = trig_offset < 0;
    wire [depth_log2:0] pre_count = neg_off ? (depth_log2 + 1)'(-trig_offset) : '0;
    logic [depth_log2:0] wr_count;
    logic [31:0] skip_count;
    logic [depth_log2-1:0] wr_ptr;
    logic [depth_log2-1:0] start_ptr;
    wire pre_ready = wr_count >= pre_count;
    wire last_store = wr_count + 1'b1 >= point_total;

    logic [acc_w-1:0] acc_v, acc_c;
    logic [depth_log2+cosine_weighted_window_w:0] wsum;
    logic [31:0] mean_v, mean_c;
    logic [cosine_weighted_window_w-1:0] weight;
    logic fin;

    // cos^4 weight across the record; phase from stored index
    function automatic logic [cosine_weighted_window_w-1:0] cosine_weighted_window_weight(input logic [depth_log2:0] idx,
                                                       input logic [depth_log2:0] total);
        logic [31:0] ph;
        logic [15:0] c, c2;
        ph = (32'(idx) << 8) / (total == '0 ? 32'h1 : 32'(total));
        // Triangle approximation of cos over -pi/2..pi/2, then raised to the 4th
        c = (ph < 32'h80) ? 16'(ph << 1) : 16'(32'h1ff - (ph << 1));
        c2 = 16'((c * c) >> 8);
        return cosine_weighted_window_w'((c2 * c2) >> 8);
    endfunction

    always_comb begin
        weight = window_sel ? cosine_weighted_window_weight(wr_count, point_total) : '1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= st_idle;
            wr_count <= '0;
            wr_ptr <= '0;
            start_ptr <= '0;
            skip_count <= '0;
            data_valid <= 1'b0;
            measure_pending <= 1'b0;
            acc_v <= '0;
            acc_c <= '0;
            wsum <= '0;
            fin <= 1'b0;
        end else begin
            fin <= 1'b0;
            if (cmd_measure) begin
                measure_pending <= 1'b1;
            end
            if (cmd_cancel) begin
                state <= st_idle;
                measure_pending <= 1'b0;
            end else begin
                unique case (state)
                    st_idle: begin
                        // Triggers ignored here
                        if (cmd_arm || cmd_measure) begin
                            state <= neg_off ? st_pre : st_wait;
                            wr_count <= '0;
                            wr_ptr <= '0;
                            data_valid <= 1'b0;
                        end
                    end
                    st_pre: begin
                        if (sample_strobe) begin
                            volt_mem[wr_ptr] <= volt_sample;
                            curr_mem[wr_ptr] <= (dual_converter || quantity_sel) ? curr_sample : '0;
                            wr_ptr <= wr_ptr + 1'b1;
                            if (!pre_ready) begin
                                wr_count <= wr_count + 1'b1;
                            end
                        end
                        // Early trigger ignored until pre count filled
                        if (trig_event && pre_ready) begin
                            state <= st_post;
                            // A sample stored at the trigger edge is the newest pre-trigger entry
                            start_ptr <= wr_ptr + depth_log2'(sample_strobe) - depth_log2'(pre_count);
                            measure_pending <= 1'b0;
                            acc_v <= '0;
                            acc_c <= '0;
                            wsum <= '0;
                        end
                    end
                    st_wait: begin
                        if (trig_event) begin
                            state <= st_post;
                            skip_count <= trig_offset;
                            start_ptr <= wr_ptr;
                            measure_pending <= 1'b0;
                            acc_v <= '0;
                            acc_c <= '0;
                            wsum <= '0;
                        end
                    end
                    st_post: begin
                        if (sample_strobe) begin
                            if (skip_count != '0) begin
                                skip_count <= skip_count - 1'b1;
                            end else begin
                                volt_mem[wr_ptr] <= volt_sample;
                                curr_mem[wr_ptr] <= (dual_converter || quantity_sel) ? curr_sample : '0;
                                wr_ptr <= wr_ptr + 1'b1;
                                wr_count <= wr_count + 1'b1;
                                acc_v <= acc_v + acc_w'(volt_sample * weight);
                                acc_c <= acc_c + acc_w'(curr_sample * weight);
                                wsum <= wsum + ($bits(wsum))'(weight);
                                if (last_store) begin
                                    state <= st_idle;
                                    data_valid <= 1'b1;
                                    fin <= 1'b1;
                                end
                            end
                        end
                    end
                endcase
            end
        end
    end

    // Mean of the post-trigger samples (pre-trigger samples stay raw only)
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mean_v <= '0;
            mean_c <= '0;
        end else if (fin) begin
            mean_v <= 32'(acc_v / (wsum == '0 ? 1 : wsum));
            mean_c <= 32'(acc_c / (wsum == '0 ? 1 : wsum));
        end
    end

    // ===================================================
    // Register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interval_ticks <= digitizer_pkg::min_interval_ticks;
            point_total <= (depth_log2 + 1)'(depth);
            trig_offset <= '0;
            window_sel <= 1'b0;
            quantity_sel <= 1'b0;
            src_sel <= 2'(digitizer_pkg::src_bus);
            src_index <= '0;
            read_index <= '0;
        end else if (access_write) begin
            unique case (paddr)
                digitizer_pkg::interval_addr: begin
                    interval_ticks <= round_ticks(pwdata);
                end
                digitizer_pkg::points_addr: point_total <= pwdata[depth_log2:0];
                digitizer_pkg::offset_addr: trig_offset <= pwdata;
                digitizer_pkg::config_addr: begin
                    window_sel <= pwdata[digitizer_pkg::cfg_window_bit];
                    quantity_sel <= pwdata[digitizer_pkg::cfg_quantity_bit];
                    src_sel <= pwdata[digitizer_pkg::cfg_src_lsb +: 2];
                    src_index <= pwdata[digitizer_pkg::cfg_sel_lsb +: 4];
                end
                digitizer_pkg::read_addr: read_index <= pwdata[depth_log2-1:0];
                default: ;
            endcase
        end
    end

    // ===================================================
    // Read path (raw samples from start of record)
    wire [depth_log2-1:0] rd_ptr = start_ptr + read_index;
    logic [31:0] next_prdata;
    always_comb begin
        unique case (paddr)
            digitizer_pkg::interval_addr: next_prdata = 32'(interval_ticks) * 32'(digitizer_pkg::base_tick_ns);
            digitizer_pkg::points_addr: next_prdata = 32'(point_total);
            digitizer_pkg::offset_addr: next_prdata = trig_offset;
            digitizer_pkg::config_addr: next_prdata = {20'h0, src_index, 2'h0, src_sel, 2'h0, quantity_sel,
                window_sel};
            digitizer_pkg::status_addr: next_prdata = {28'h0, measure_pending, state != st_idle,
                data_valid, state != st_idle};
            digitizer_pkg::read_addr: next_prdata = 32'(read_index);
            digitizer_pkg::volt_data_addr: next_prdata = 32'(volt_mem[rd_ptr]);
            digitizer_pkg::curr_data_addr: next_prdata = 32'(curr_mem[rd_ptr]);
            digitizer_pkg::mean_volt_addr: next_prdata = mean_v;
            digitizer_pkg::mean_curr_addr: next_prdata = mean_c;
            default: next_prdata = 32'h0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            armed <= 1'b0;
            acq_done <= 1'b0;
        end else begin
            // pready rises one cycle into the access phase, later for held-off fetches
            pready <= psel && penable && !pready && !fetch_hold;
            pslverr <= psel && penable && !pready && !fetch_hold && !addr_known;
            if (psel && penable && !pready && !fetch_hold) begin
                prdata <= pwrite ? 32'h0 : next_prdata;
            end
            armed <= state != st_idle;
            acq_done <= data_valid;
        end
    end

    // ===================================================
    // Assertions
    a_idle_after_reset: assert property (@(posedge pclk) $rose(presetn) |-> state == st_idle)
        else $error("state not idle after reset");
    a_cancel_to_idle: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_cancel |=> state == st_idle)
        else $error("cancel did not return to idle");
    a_arm_leaves_idle: assert property (@(posedge pclk) disable iff (!presetn)
        state == st_idle && cmd_arm && !cmd_cancel |=> state != st_idle)
        else $error("arm ignored");
    a_idle_ignores_trig: assert property (@(posedge pclk) disable iff (!presetn)
        state == st_idle && !cmd_arm && !cmd_measure |=> state == st_idle)
        else $error("idle left without arm");
    a_early_trig_ignored: assert property (@(posedge pclk) disable iff (!presetn)
        state == st_pre && !pre_ready && !cmd_cancel |=> state != st_post)
        else $error("early trigger accepted");
    a_done_to_idle: assert property (@(posedge pclk) disable iff (!presetn)
        fin |-> state == st_idle && data_valid)
        else $error("not idle at completion");
    a_fetch_held: assert property (@(posedge pclk) disable iff (!presetn)
        fetch_hold |=> !pready)
        else $error("fetch answered before completion");
    a_rect_default: assert property (@(posedge pclk) $rose(presetn) |-> !window_sel)
        else $error("window not rectangular at reset");
    a_interval_min: assert property (@(posedge pclk) disable iff (!presetn)
        interval_ticks >= digitizer_pkg::min_interval_ticks)
        else $error("interval below one tick");
    a_trig_cmd_fires: assert property (@(posedge pclk) disable iff (!presetn)
        state == st_wait && cmd_trig && !cmd_cancel |=> state == st_post)
        else $error("immediate trigger ignored");
    c_full_acq: cover property (@(posedge pclk) disable iff (!presetn) fin);
    c_pre_trig: cover property (@(posedge pclk) disable iff (!presetn) state == st_pre ##1 state == st_post);
    c_cancel_wait: cover property (@(posedge pclk) disable iff (!presetn) state == st_wait && cmd_cancel);
    c_held_fetch: cover property (@(posedge pclk) disable iff (!presetn) fetch_hold ##[1:1000] pready);
endmodule

// ==== shared/digitizer_pkg.sv ====
package digitizer_pkg;
    // ===================================================
    // Register byte offsets
    localparam logic [7:0] ctrl_addr = 8'h00;
    localparam logic [7:0] interval_addr = 8'h04;
    localparam logic [7:0] points_addr = 8'h08;
    localparam logic [7:0] offset_addr = 8'h0c;
    localparam logic [7:0] config_addr = 8'h10;
    localparam logic [7:0] status_addr = 8'h14;
    localparam logic [7:0] read_addr = 8'h18;
    localparam logic [7:0] volt_data_addr = 8'h1c;
    localparam logic [7:0] curr_data_addr = 8'h20;
    localparam logic [7:0] mean_volt_addr = 8'h24;
    localparam logic [7:0] mean_curr_addr = 8'h28;
    // ===================================================
    // Command bits in the control register (write-one pulses)
    localparam int cmd_arm_bit = 0;
    localparam int cmd_trig_bit = 1;
    localparam int cmd_cancel_bit = 2;
    localparam int cmd_measure_bit = 3;
    localparam int cmd_bus_trig_bit = 4;
    // Config register fields
    localparam int cfg_window_bit = 0;
    localparam int cfg_quantity_bit = 1;
    localparam int cfg_src_lsb = 4;
    localparam int cfg_sel_lsb = 8;
    // Status bits
    localparam int st_armed_bit = 0;
    localparam int st_done_bit = 1;
    localparam int st_busy_bit = 2;
    localparam int st_pending_bit = 3;
    // ===================================================
    // Timing: base tick 20.48 us = 20480 ns
    localparam int base_tick_ns = 20480;
    localparam int clk_period_ns = 4;
    localparam int tick_cycles = base_tick_ns / clk_period_ns;
    // Fastest interval: one tick, 48.8 kHz, within the 50 kHz ceiling
    localparam int max_rate_hz = 50000;
    localparam logic [15:0] min_interval_ticks = 16'h0001;
    // Hanning table size (quarter period, cos^4 shape)
    localparam int cosine_weighted_window_bits = 6;
    typedef enum logic [1:0] {src_bus, src_pin, src_transient} trig_src_e;
endpackage
